// File: design/cpu_sideband.sv
// Processor sideband control: warm restart, local interrupts, numeric error, lock, snoop stall
// Function
// R1 - A warm restart clears the integer registers and leaves caches and float registers alone.
// R2 - After a warm restart fetch resumes at the restart vector chosen at power-on configuration.
// R3 - Snoops keep being serviced while warm restart is held asserted.
// R4 - The outside agent holds warm restart valid with target ready of the I/O write to be seen.
// R5 - Warm restart seen asserted at reset release starts the built-in self-test.
// R6 - With the local interrupt controller off, pin 0 acts as the maskable interrupt.
// R7 - With the local interrupt controller off, pin 1 acts as the nonmaskable interrupt.
// R8 - The local interrupt controller is enabled after reset so both pins keep their local role.
// R9 - Both local interrupt pins are accepted asynchronously to the bus clock.
// R10 - The atomic hold stays asserted from the first to the last transaction of a locked run.
// R11 - A priority agent waits for atomic hold to drop before it takes the bus.
// R12 - With ignore numeric error asserted a pending numeric error is ignored.
// R13 - Without it a non-control float instruction after a float error raises an exception.
// R14 - The ignore numeric error input has no effect while the native numeric error bit is set.
// R15 - An internal error asserts the internal error output and requests a halt cycle; the code requests it only for the first error after reset.
// R16 - A snoop stall is signalled by driving both snoop match outputs together.
// R17 - Every asynchronous sideband input passes a two-stage synchroniser before use.
`default_nettype none
module cpu_sideband
   import sideband_pkg::*;
#(
   parameter logic [31:0] RESTART_VECTOR = RESTART_VECTOR_RST
) (
   // Clock and reset
   input wire logic CLOCK,
   input wire logic RST_N,
   // Asynchronous sideband pins
   input wire logic WARM_RESTART_N,
   input wire logic [LOCAL_IRQ_W-1:0] LOCAL_IRQ_PINS,
   input wire logic IGNORE_NUMERIC_ERR_N,
   // Core configuration and events
   input wire logic LOCAL_IRQ_CTRL_EN_WR,
   input wire logic LOCAL_IRQ_CTRL_EN_VAL,
   input wire logic NUMERIC_ERR_NATIVE,
   input wire logic FP_ERROR_EVENT,
   input wire logic FP_ERROR_CLEAR,
   input wire logic FP_NONCTRL_ISSUE,
   input wire logic INTERNAL_ERR_EVENT,
   input wire logic LOCKED_SEQ_START,
   input wire logic LOCKED_SEQ_END,
   input wire logic SNOOP_REQ,
   input wire logic SNOOP_STALL_NEED,
   input wire logic SELFTEST_DONE,
   // Core controls
   output logic INT_REG_CLEAR,
   output logic FETCH_RESTART,
   output logic [31:0] FETCH_VECTOR,
   output logic SNOOP_SERVICE,
   output logic SELFTEST_RUN,
   output logic LOCAL_IRQ_CTRL_EN,
   output logic [LOCAL_IRQ_W-1:0] LOCAL_IRQ_OUT,
   output logic MASKABLE_IRQ,
   output logic NONMASK_IRQ,
   output logic FP_EXCEPTION,
   output logic HALT_CYCLE_REQ,
   // Bus side pins
   output logic INTERNAL_ERR_N,
   output logic ATOMIC_HOLD_N,
   output logic SNOOP_MATCH_CLEAN_N,
   output logic SNOOP_MATCH_DIRTY_N
);
   // ------------------------------------------------------------
   // Synchronisers
   // ------------------------------------------------------------
   logic restart_n_s;
   logic ignore_n_s;
   logic [LOCAL_IRQ_W-1:0] irq_s;

   sideband_sync #(.RESET_VAL(ACTIVE_LOW_OFF)) u_sync_restart ( // R17
      .clk(CLOCK),
      .rst_n(RST_N),
      .d(WARM_RESTART_N),
      .q(restart_n_s)
   );

   sideband_sync #(.RESET_VAL(ACTIVE_LOW_OFF)) u_sync_ignore ( // R17
      .clk(CLOCK),
      .rst_n(RST_N),
      .d(IGNORE_NUMERIC_ERR_N),
      .q(ignore_n_s)
   );

   // Interrupt pins idle low; restart and ignore pins idle high
   genvar gi;
   generate
      for (gi = 0; gi < LOCAL_IRQ_W; gi++) begin : g_irq_sync
         sideband_sync #(.RESET_VAL(1'b0)) u_sync_irq ( // R9
            .clk(CLOCK),
            .rst_n(RST_N),
            .d(LOCAL_IRQ_PINS[gi]),
            .q(irq_s[gi])
         );
      end
   endgenerate

   // ------------------------------------------------------------
   // Warm restart and self-test
   // ------------------------------------------------------------
   logic restart_prev_r;
   logic in_reset_r;
   logic int_clear_r;
   logic fetch_restart_r;
   logic selftest_r;
   logic [31:0] vector_r;

   // Integer register clear follows the synchronised pin level
   always_ff @(posedge CLOCK) begin
      if (!RST_N) begin
         int_clear_r <= 1'b0;
      end else begin
         int_clear_r <= !restart_n_s; // R1
      end
   end

   // Fetch restart pulses once when the synchronised pin releases
   always_ff @(posedge CLOCK) begin
      if (!RST_N) begin
         restart_prev_r <= ACTIVE_LOW_OFF;
         fetch_restart_r <= 1'b0;
      end else begin
         restart_prev_r <= restart_n_s;
         fetch_restart_r <= restart_n_s && !restart_prev_r; // R2
      end
   end

   // Restart vector held in a flop so the output port is registered
   always_ff @(posedge CLOCK) begin
      vector_r <= RESTART_VECTOR; // R2
   end

   // Strap capture for the self-test request: the pin synchroniser is held in
   // reset and cannot show the pin level at release, so a private two-flop
   // chain keeps running through reset.
   logic strap_meta_r;
   logic strap_r;

   always_ff @(posedge CLOCK) begin
      strap_meta_r <= WARM_RESTART_N;
      strap_r <= strap_meta_r;
   end

   always_ff @(posedge CLOCK) begin
      if (!RST_N) begin
         in_reset_r <= 1'b1;
         selftest_r <= 1'b0;
      end else begin
         in_reset_r <= 1'b0;
         if (in_reset_r && !strap_r) begin
            selftest_r <= 1'b1; // R5
         end else if (SELFTEST_DONE) begin
            selftest_r <= 1'b0;
         end
      end
   end

   // ------------------------------------------------------------
   // Snoop service
   // ------------------------------------------------------------
   logic snoop_svc_r;
   logic clean_n_r;
   logic dirty_n_r;

   always_ff @(posedge CLOCK) begin
      if (!RST_N) begin
         snoop_svc_r <= 1'b0;
      end else begin
         snoop_svc_r <= SNOOP_REQ; // R3
      end
   end

   // Stall is flagged on both match outputs in the same cycle
   always_ff @(posedge CLOCK) begin
      if (!RST_N) begin
         clean_n_r <= ACTIVE_LOW_OFF;
         dirty_n_r <= ACTIVE_LOW_OFF;
      end else begin
         clean_n_r <= !(SNOOP_REQ && SNOOP_STALL_NEED); // R16
         dirty_n_r <= !(SNOOP_REQ && SNOOP_STALL_NEED); // R16
      end
   end

   // ------------------------------------------------------------
   // Local interrupt pins
   // ------------------------------------------------------------
   logic ctrl_en_r;
   logic [LOCAL_IRQ_W-1:0] lirq_r;
   logic maskable_r;
   logic nonmask_r;

   // Controller enable comes out of reset set
   always_ff @(posedge CLOCK) begin
      if (!RST_N) begin
         ctrl_en_r <= IRQ_CTRL_EN_RST; // R8
      end else if (LOCAL_IRQ_CTRL_EN_WR) begin
         ctrl_en_r <= LOCAL_IRQ_CTRL_EN_VAL;
      end
   end

   always_ff @(posedge CLOCK) begin
      if (!RST_N) begin
         lirq_r <= '0;
      end else begin
         lirq_r <= ctrl_en_r ? irq_s : '0; // R8
      end
   end

   // Legacy routing of the pins while the controller is off
   always_ff @(posedge CLOCK) begin
      if (!RST_N) begin
         maskable_r <= 1'b0;
         nonmask_r <= 1'b0;
      end else begin
         maskable_r <= !ctrl_en_r && irq_s[IRQ_PIN_MASKABLE]; // R6
         nonmask_r <= !ctrl_en_r && irq_s[IRQ_PIN_NONMASK]; // R7
      end
   end

   // ------------------------------------------------------------
   // Numeric error handling
   // ------------------------------------------------------------
   logic fp_pending_r;
   logic fp_exc_r;
   logic ignore_eff;

   // Native error mode disregards the ignore pin
   assign ignore_eff = !ignore_n_s && !NUMERIC_ERR_NATIVE; // R14

   // Set wins over clear so an error in the clearing cycle is kept
   always_ff @(posedge CLOCK) begin
      if (!RST_N) begin
         fp_pending_r <= 1'b0;
      end else if (FP_ERROR_EVENT) begin
         fp_pending_r <= 1'b1;
      end else if (FP_ERROR_CLEAR) begin
         fp_pending_r <= 1'b0;
      end
   end

   // Exception is raised one cycle after the instruction is issued
   always_ff @(posedge CLOCK) begin
      if (!RST_N) begin
         fp_exc_r <= 1'b0;
      end else begin
         fp_exc_r <= FP_NONCTRL_ISSUE && fp_pending_r && !ignore_eff; // R12 R13
      end
   end

   // ------------------------------------------------------------
   // Internal error and atomic hold
   // ------------------------------------------------------------
   logic internal_err_n_n_r;
   logic halt_r;
   logic hold_n_r;

   always_ff @(posedge CLOCK) begin
      if (!RST_N) begin
         internal_err_n_n_r <= ACTIVE_LOW_OFF;
      end else if (INTERNAL_ERR_EVENT) begin
         internal_err_n_n_r <= 1'b0; // R15
      end
   end

   // Only the first error asks for a halt cycle
   always_ff @(posedge CLOCK) begin
      if (!RST_N) begin
         halt_r <= 1'b0;
      end else begin
         halt_r <= INTERNAL_ERR_EVENT && internal_err_n_n_r; // R15
      end
   end

   // Start wins over end so back to back locked runs stay joined
   always_ff @(posedge CLOCK) begin
      if (!RST_N) begin
         hold_n_r <= ACTIVE_LOW_OFF;
      end else if (LOCKED_SEQ_START) begin
         hold_n_r <= 1'b0; // R10
      end else if (LOCKED_SEQ_END) begin
         hold_n_r <= ACTIVE_LOW_OFF; // R10
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   assign INT_REG_CLEAR = int_clear_r;
   assign FETCH_RESTART = fetch_restart_r;
   assign FETCH_VECTOR = vector_r; // R2
   assign SNOOP_SERVICE = snoop_svc_r;
   assign SELFTEST_RUN = selftest_r;
   assign LOCAL_IRQ_CTRL_EN = ctrl_en_r;
   assign LOCAL_IRQ_OUT = lirq_r;
   assign MASKABLE_IRQ = maskable_r;
   assign NONMASK_IRQ = nonmask_r;
   assign FP_EXCEPTION = fp_exc_r;
   assign HALT_CYCLE_REQ = halt_r;
   assign INTERNAL_ERR_N = internal_err_n_n_r;
   assign ATOMIC_HOLD_N = hold_n_r;
   assign SNOOP_MATCH_CLEAN_N = clean_n_r;
   assign SNOOP_MATCH_DIRTY_N = dirty_n_r;
endmodule : cpu_sideband
`default_nettype wire

// File: design/sideband_pkg.sv
// Constants for the processor sideband control block
`default_nettype none
package sideband_pkg;
   // Synchroniser depth
   localparam int SYNC_STAGES = 2;
   // Number of local interrupt pins
   localparam int LOCAL_IRQ_W = 2;
   // Reset values
   localparam logic IRQ_CTRL_EN_RST = 1'b1;
   localparam logic ACTIVE_LOW_OFF = 1'b1;
   localparam logic [31:0] RESTART_VECTOR_RST = 32'hFFFF_FFF0;
   // Bit positions within the local interrupt pin group
   localparam int IRQ_PIN_MASKABLE = 0;
   localparam int IRQ_PIN_NONMASK = 1;
endpackage : sideband_pkg
`default_nettype wire

// File: design/sideband_sync.sv
// Two-flop synchroniser for an asynchronous input bit
`default_nettype none
module sideband_sync
   import sideband_pkg::*;
#(
   parameter logic RESET_VAL = 1'b0
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Data
   input wire logic d,
   output logic q
);
   logic meta_r;
   logic q_r;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         meta_r <= RESET_VAL;
         q_r <= RESET_VAL;
      end else begin
         meta_r <= d;
         q_r <= meta_r;
      end
   end

   assign q = q_r;
endmodule : sideband_sync
`default_nettype wire

// File: tb/cpu_sideband_chk.sv
// Port assertions for the sideband block
`default_nettype none
module cpu_sideband_chk
   import sideband_pkg::*;
#(
   parameter logic [31:0] RESTART_VECTOR = RESTART_VECTOR_RST
) (
   // Watched ports
   input wire logic CLOCK,
   input wire logic RST_N,
   input wire logic WARM_RESTART_N,
   input wire logic IGNORE_NUMERIC_ERR_N,
   input wire logic [LOCAL_IRQ_W-1:0] LOCAL_IRQ_PINS,
   input wire logic NUMERIC_ERR_NATIVE,
   input wire logic FP_ERROR_EVENT,
   input wire logic FP_ERROR_CLEAR,
   input wire logic FP_NONCTRL_ISSUE,
   input wire logic INTERNAL_ERR_EVENT,
   input wire logic LOCKED_SEQ_START,
   input wire logic LOCKED_SEQ_END,
   input wire logic SNOOP_REQ,
   input wire logic SNOOP_STALL_NEED,
   input wire logic INT_REG_CLEAR,
   input wire logic FETCH_RESTART,
   input wire logic [31:0] FETCH_VECTOR,
   input wire logic SNOOP_SERVICE,
   input wire logic LOCAL_IRQ_CTRL_EN,
   input wire logic MASKABLE_IRQ,
   input wire logic NONMASK_IRQ,
   input wire logic FP_EXCEPTION,
   input wire logic HALT_CYCLE_REQ,
   input wire logic INTERNAL_ERR_N,
   input wire logic ATOMIC_HOLD_N,
   input wire logic SNOOP_MATCH_CLEAN_N,
   input wire logic SNOOP_MATCH_DIRTY_N
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge CLOCK); endclocking
   default disable iff (!RST_N);
   a_restart_clear: assert property ((RST_N && !WARM_RESTART_N) [*3] |=> INT_REG_CLEAR)
      else $error("no clear");
   a_fetch_vector: assert property (FETCH_RESTART |->
      FETCH_VECTOR == RESTART_VECTOR ##1 !FETCH_RESTART) else $error("bad fetch");
   a_snoop_kept: assert property (SNOOP_REQ |=> SNOOP_SERVICE)
      else $error("snoop lost");
   a_snoop_stall: assert property (SNOOP_REQ && SNOOP_STALL_NEED |=>
      !SNOOP_MATCH_CLEAN_N && !SNOOP_MATCH_DIRTY_N) else $error("no stall");
   a_stall_release: assert property (!(SNOOP_REQ && SNOOP_STALL_NEED) |=>
      SNOOP_MATCH_CLEAN_N && SNOOP_MATCH_DIRTY_N) else $error("stall stuck");
   a_nonmask_route: assert property ((!LOCAL_IRQ_CTRL_EN &&
      LOCAL_IRQ_PINS[IRQ_PIN_NONMASK]) [*3] ##1 !LOCAL_IRQ_CTRL_EN |-> NONMASK_IRQ)
      else $error("no nonmaskable");
   a_ignore_err: assert property (FP_ERROR_EVENT ##1 (FP_NONCTRL_ISSUE &&
      !NUMERIC_ERR_NATIVE && !$past(IGNORE_NUMERIC_ERR_N, 2)) |=> !FP_EXCEPTION)
      else $error("error not ignored");
   a_raise_err: assert property (FP_ERROR_EVENT ##1 (FP_NONCTRL_ISSUE &&
      $past(IGNORE_NUMERIC_ERR_N, 2)) |=> FP_EXCEPTION) else $error("no exception");
   a_maskable_route: assert property ((!LOCAL_IRQ_CTRL_EN &&
      LOCAL_IRQ_PINS[IRQ_PIN_MASKABLE]) [*3] ##1 !LOCAL_IRQ_CTRL_EN |-> MASKABLE_IRQ)
      else $error("no maskable");
   a_native_err: assert property (FP_ERROR_EVENT ##1 (FP_NONCTRL_ISSUE &&
      NUMERIC_ERR_NATIVE && !FP_ERROR_CLEAR) |=> FP_EXCEPTION) else $error("no fp exc");
   a_err_first: assert property (INTERNAL_ERR_EVENT && INTERNAL_ERR_N |=>
      !INTERNAL_ERR_N && HALT_CYCLE_REQ) else $error("no error out");
   a_hold_span: assert property (LOCKED_SEQ_START || !ATOMIC_HOLD_N && !LOCKED_SEQ_END
      |=> !ATOMIC_HOLD_N) else $error("hold gap");
endmodule : cpu_sideband_chk
bind cpu_sideband cpu_sideband_chk #(.RESTART_VECTOR(RESTART_VECTOR)) chk (.*);
`default_nettype wire

// File: tb/sideband_partner.sv
// Priority bus agent model facing the sideband block
`default_nettype none
module sideband_partner (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Arbitration
   input wire logic atomic_hold_n,
   input wire logic want_bus,
   output logic owns_bus
);
   timeunit 1ns;
   timeprecision 1ns;
   always_ff @(posedge clk) begin
      if (!rst_n || !want_bus) begin
         owns_bus <= 1'b0;
      end else if (atomic_hold_n) begin
         owns_bus <= 1'b1;
      end
   end
endmodule : sideband_partner
`default_nettype wire

// File: tb/tb_cpu_sideband.sv
// Randomised self-checking bench for the sideband block
`default_nettype none
module tb_cpu_sideband import sideband_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [31:0] VEC = 32'h0000_0A5C;
   logic CLOCK, RST_N, WARM_RESTART_N, IGNORE_NUMERIC_ERR_N, LOCAL_IRQ_CTRL_EN_WR;
   logic LOCAL_IRQ_CTRL_EN_VAL, NUMERIC_ERR_NATIVE, FP_ERROR_EVENT, FP_ERROR_CLEAR;
   logic FP_NONCTRL_ISSUE, INTERNAL_ERR_EVENT, LOCKED_SEQ_START, LOCKED_SEQ_END, SNOOP_REQ;
   logic SNOOP_STALL_NEED, SELFTEST_DONE, INT_REG_CLEAR, FETCH_RESTART, SNOOP_SERVICE;
   logic SELFTEST_RUN, LOCAL_IRQ_CTRL_EN, MASKABLE_IRQ, NONMASK_IRQ, FP_EXCEPTION;
   logic HALT_CYCLE_REQ, INTERNAL_ERR_N, ATOMIC_HOLD_N, SNOOP_MATCH_CLEAN_N, SNOOP_MATCH_DIRTY_N;
   logic [LOCAL_IRQ_W-1:0] LOCAL_IRQ_PINS, LOCAL_IRQ_OUT;
   logic [31:0] FETCH_VECTOR, r;
   logic want, owns, exp_hold_n, err_seen, snoop_q, owns_q, hold_q;
   int fail_count = 0, n_tests = 0, cycles = 0, pulses;
   integer seed = 32'h53AE;
   cpu_sideband #(.RESTART_VECTOR(VEC)) dut (.*);
   sideband_partner agent (.clk(CLOCK), .rst_n(RST_N), .atomic_hold_n(ATOMIC_HOLD_N),
      .want_bus(want), .owns_bus(owns));
   task automatic check(input logic got, input logic exp, input string what);
      n_tests++;
      if (got !== exp) begin
         fail_count++;
         $display("ERROR %0t %s", $time, what);
      end
   endtask : check
   function automatic logic next_hold_n(input logic cur, input logic s, input logic e);
      return s ? 1'b0 : (e ? 1'b1 : cur);
   endfunction : next_hold_n
   task automatic conclude;
      $display("comparisons %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : conclude
   always #5 CLOCK = ~CLOCK;
   always @(posedge CLOCK) begin
      cycles++;
      if (cycles == 3000) begin
         fail_count++;
         $display("ERROR %0t timeout", $time);
         conclude();
      end else if (!RST_N) begin
         exp_hold_n = 1'b1;
         snoop_q = 1'b0;
         owns_q = 1'b0;
         hold_q = 1'b1;
      end else begin
         check(ATOMIC_HOLD_N, exp_hold_n, "hold");
         check(SNOOP_SERVICE, snoop_q, "snoop");
         if (owns && !owns_q) begin
            check(hold_q, 1'b1, "takeover");
         end
         exp_hold_n = next_hold_n(exp_hold_n, LOCKED_SEQ_START, LOCKED_SEQ_END);
         snoop_q = SNOOP_REQ;
         owns_q = owns;
         hold_q = ATOMIC_HOLD_N;
      end
   end
   initial begin
      CLOCK = 1'b0;
      RST_N = 1'b0;
      {WARM_RESTART_N, IGNORE_NUMERIC_ERR_N, want, err_seen} = 4'h4;
      {LOCAL_IRQ_CTRL_EN_WR, LOCAL_IRQ_CTRL_EN_VAL, NUMERIC_ERR_NATIVE, FP_ERROR_EVENT} = '0;
      {FP_ERROR_CLEAR, FP_NONCTRL_ISSUE, INTERNAL_ERR_EVENT, LOCKED_SEQ_START} = '0;
      {LOCKED_SEQ_END, SNOOP_REQ, SNOOP_STALL_NEED, SELFTEST_DONE, LOCAL_IRQ_PINS} = '0;
      repeat (4) @(posedge CLOCK);
      RST_N <= 1'b1;
      LOCAL_IRQ_PINS <= 2'h2;
      #1;
      check(LOCAL_IRQ_CTRL_EN, 1'b1, "enable reset");
      check(INTERNAL_ERR_N, 1'b1, "error reset");
      repeat (3) @(posedge CLOCK);
      #1;
      check(SELFTEST_RUN, 1'b1, "self-test");
      check(INT_REG_CLEAR, 1'b1, "reg clear");
      check(LOCAL_IRQ_OUT === 2'h2 && !NONMASK_IRQ, 1'b1, "local role");
      @(posedge CLOCK);
      WARM_RESTART_N <= 1'b1;
      SELFTEST_DONE <= 1'b1;
      pulses = 0;
      repeat (8) begin
         @(posedge CLOCK);
         SELFTEST_DONE <= 1'b0;
         #1;
         if (FETCH_RESTART === 1'b1) begin
            pulses++;
            check(FETCH_VECTOR === VEC, 1'b1, "vector");
         end
      end
      check(pulses == 1, 1'b1, "fetch pulse");
      check(SELFTEST_RUN, 1'b0, "self-test end");
      check(INT_REG_CLEAR, 1'b0, "clear end");
      repeat (400) begin
         @(posedge CLOCK);
         r = $random(seed);
         {WARM_RESTART_N, LOCAL_IRQ_PINS, IGNORE_NUMERIC_ERR_N} <= {r[0] | r[1], r[3:2], r[4]};
         {LOCAL_IRQ_CTRL_EN_WR, LOCAL_IRQ_CTRL_EN_VAL, NUMERIC_ERR_NATIVE} <= {r[5] & r[6], r[8:7]};
         {FP_ERROR_EVENT, FP_ERROR_CLEAR, FP_NONCTRL_ISSUE} <= {r[9], r[10] & r[11], r[12]};
         INTERNAL_ERR_EVENT <= (r[15:13] == 3'h0);
         {LOCKED_SEQ_START, LOCKED_SEQ_END} <= {r[16] & r[17], r[18] & r[19]};
         {SNOOP_REQ, SNOOP_STALL_NEED, SELFTEST_DONE, want} <= r[23:20];
         err_seen = err_seen | (r[15:13] == 3'h0);
      end
      @(posedge CLOCK);
      INTERNAL_ERR_EVENT <= 1'b0;
      repeat (2) @(posedge CLOCK);
      #1;
      check(INTERNAL_ERR_N, !err_seen, "error sticky");
      conclude();
   end
endmodule : tb_cpu_sideband
`default_nettype wire
